// ==== ot_stamp_regs.svh ====
`ifndef OT_STAMP_REGS_SVH
`define OT_STAMP_REGS_SVH

// =============================================================
// register offsets
`define OT_ADDR_MONTH 8'h24
`define OT_ADDR_YEAR  8'h25
`define OT_ADDR_CTRL  8'h30
`define OT_ADDR_STAT  8'h31
// =============================================================
// control fields
`define OT_CTRL_EN_BIT    0
`define OT_CTRL_OW_BIT    1
`define OT_CTRL_RST_BIT   2
// status fields
`define OT_STAT_VALID_BIT 0
// =============================================================
// reset values
`define OT_MONTH_RESET 5'h00
`define OT_YEAR_RESET  8'h00
`define OT_CTRL_RESET  2'h0
`endif

// ==== ot_stamp_pkg.sv ====
package ot_stamp_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {CAP_IDLE, CAP_HELD} cap_state_t;
endpackage : ot_stamp_pkg

// ==== ot_stamp_capture.sv ====
`timescale 1ns/1ns
`include "ot_stamp_regs.svh"
// =============================================================
// capture decision: enable plus first/last selection
module ot_stamp_capture (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic enable_i,
    input  wire logic overwrite_i,
    input  wire logic event_i,
    input  wire logic clear_i,
    output logic      take_o,
    output logic      held_o
);
    ot_stamp_pkg::cap_state_t state_q;

    always_comb begin
        take_o = 1'b0;
        if (enable_i && event_i) begin
            case (state_q)
                ot_stamp_pkg::CAP_IDLE: take_o = 1'b1;
                ot_stamp_pkg::CAP_HELD: take_o = overwrite_i;
                default: take_o = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= ot_stamp_pkg::CAP_IDLE;
        end else if (ce_i) begin
            if (take_o) begin
                state_q <= ot_stamp_pkg::CAP_HELD;
            end else if (clear_i) begin
                state_q <= ot_stamp_pkg::CAP_IDLE;
            end
        end
    end

    assign held_o = (state_q == ot_stamp_pkg::CAP_HELD);
endmodule : ot_stamp_capture

// ==== ot_stamp_month_year.sv ====
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "ot_stamp_regs.svh"
// =============================================================
// over-temperature stamp month/year registers
module ot_stamp_month_year (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       ot_event_i,
    input  wire logic [4:0] cal_month_i,
    input  wire logic [7:0] cal_year_i
);
    logic [4:0] month_q;
    logic [7:0] year_q;
    logic [1:0] ctrl_q;
    logic       take;
    logic       held;
    logic       clr;
    logic [7:0] rdata_d;
    logic       armed_q;
    logic [4:0] model_month_q;
    logic [7:0] model_year_q;
    logic       model_take;

    // =============================================================
    // decode and BCD check helpers
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        return a == off;
    endfunction : hit

    function automatic logic bcd_ok(input logic [7:0] v);
        return (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
    endfunction : bcd_ok

    function automatic logic month_ok(input logic [4:0] m);
        logic [7:0] v;
        v = {3'h0, m};
        return bcd_ok(v) && (v >= 8'h01) && (v <= 8'h12);
    endfunction : month_ok

    // =============================================================
    // control register write
    assign clr = wr_i && hit(addr_i, `OT_ADDR_CTRL)
                 && wdata_i[`OT_CTRL_RST_BIT];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `OT_CTRL_RESET;
        end else if (ce_i && wr_i && hit(addr_i, `OT_ADDR_CTRL)) begin
            ctrl_q <= {wdata_i[`OT_CTRL_OW_BIT], wdata_i[`OT_CTRL_EN_BIT]};
        end
    end

    ot_stamp_capture u_cap (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .enable_i    (ctrl_q[0]),
        .overwrite_i (ctrl_q[1]),
        .event_i     (ot_event_i),
        .clear_i     (clr),
        .take_o      (take),
        .held_o      (held)
    );

    // =============================================================
    // stamp storage; capture wins over clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            month_q <= `OT_MONTH_RESET;
            year_q  <= `OT_YEAR_RESET;
        end else if (ce_i) begin
            if (take) begin
                month_q <= cal_month_i;
                year_q  <= cal_year_i;
            end else if (clr) begin
                month_q <= `OT_MONTH_RESET;
                year_q  <= `OT_YEAR_RESET;
            end
        end
    end

    // =============================================================
    // read port, data one cycle after strobe
    always_comb begin
        case (addr_i)
            `OT_ADDR_MONTH: rdata_d = {3'h0, month_q};
            `OT_ADDR_YEAR:  rdata_d = year_q;
            `OT_ADDR_CTRL:  rdata_d = {6'h00, ctrl_q};
            `OT_ADDR_STAT:  rdata_d = {7'h00, held};
            default:        rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            rdata_o <= rd_i ? rdata_d : 8'h00;
        end
    end

    // =============================================================
    // shadow of the stamp for the checks below
    assign model_take = ot_event_i && ctrl_q[0]
                        && (armed_q || ctrl_q[1]);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            armed_q       <= 1'b1;
            model_month_q <= `OT_MONTH_RESET;
            model_year_q  <= `OT_YEAR_RESET;
        end else if (ce_i) begin
            if (model_take) begin
                armed_q       <= 1'b0;
                model_month_q <= cal_month_i;
                model_year_q  <= cal_year_i;
            end else if (clr) begin
                armed_q       <= 1'b1;
                model_month_q <= `OT_MONTH_RESET;
                model_year_q  <= `OT_YEAR_RESET;
            end
        end
    end

    // =============================================================
    // checks
    a_month_upper: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        $past(rd_i) && $past(addr_i) == `OT_ADDR_MONTH && $past(ce_i)
        |-> rdata_o[7:5] == 3'h0)
        else $error("month upper bits not zero");

    a_month_cap: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && take
        |=> month_q == $past(cal_month_i))
        else $error("month not captured");

    a_no_cap_off: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && !ctrl_q[0] && !clr
        |=> $stable(year_q))
        else $error("capture while disabled");

    a_first_kept: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && held && !ctrl_q[1] && !clr
        |=> $stable(month_q))
        else $error("first stamp overwritten");

    a_last_taken: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && ot_event_i && ctrl_q == 2'h3
        |=> year_q == $past(cal_year_i))
        else $error("last stamp not taken");

    a_year_reset: assert property (@(posedge clk_i)
        !rst_n_i
        |=> year_q == 8'h00)
        else $error("year reset wrong");

    a_year_clear: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && clr && !take
        |=> year_q == 8'h00)
        else $error("year not cleared");

    a_year_cap: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && take
        |=> year_q == $past(cal_year_i))
        else $error("year not captured");

    a_month_clear: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && clr && !take
        |=> month_q == `OT_MONTH_RESET)
        else $error("month not cleared");

    a_held_clear: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && clr && !take
        |=> !held)
        else $error("clear did not rearm capture");

    a_held_sticky: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && held && !clr
        |=> held)
        else $error("held stamp lost");

    a_first_taken: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && ot_event_i && ctrl_q[0] && !held
        |=> held)
        else $error("first event not taken");

    a_no_take_off: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !ctrl_q[0]
        |-> !take)
        else $error("take while disabled");

    a_month_read: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && rd_i && hit(addr_i, `OT_ADDR_MONTH)
        |=> rdata_o == {3'h0, $past(month_q)})
        else $error("month read wrong");

    a_year_read: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && rd_i && hit(addr_i, `OT_ADDR_YEAR)
        |=> rdata_o == $past(year_q))
        else $error("year read wrong");

    a_ctrl_read: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && rd_i && hit(addr_i, `OT_ADDR_CTRL)
        |=> rdata_o == {6'h00, $past(ctrl_q)})
        else $error("control read wrong");

    a_stat_read: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && rd_i && hit(addr_i, `OT_ADDR_STAT)
        |=> rdata_o == {7'h00, $past(held)})
        else $error("status read wrong");

    a_rdata_idle: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && !rd_i
        |=> rdata_o == 8'h00)
        else $error("read data not idle");

    a_ce_stamp: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !ce_i
        |=> $stable(month_q) && $stable(year_q))
        else $error("stamp moved while frozen");

    a_ce_regs: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !ce_i
        |=> $stable(ctrl_q) && $stable(rdata_o) && $stable(held))
        else $error("registers moved while frozen");

    a_ctrl_write: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && wr_i && hit(addr_i, `OT_ADDR_CTRL)
        |=> ctrl_q == $past(wdata_i[1:0]))
        else $error("control write lost");

    a_year_ro: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && wr_i && hit(addr_i, `OT_ADDR_YEAR) && !take
        |=> $stable(year_q))
        else $error("year written by software");

    a_model_month: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        month_q == model_month_q)
        else $error("month differs from shadow");

    a_model_year: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        year_q == model_year_q)
        else $error("year differs from shadow");

    a_model_held: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        held == !armed_q)
        else $error("held differs from shadow");

    a_model_take: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        take == model_take)
        else $error("take differs from shadow");

    a_year_bcd: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && take && bcd_ok(cal_year_i)
        |=> bcd_ok(year_q))
        else $error("year not bcd");

    a_month_range: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ce_i && take && month_ok(cal_month_i)
        |=> month_ok(month_q))
        else $error("month out of range");

    a_reset_state: assert property (@(posedge clk_i)
        !rst_n_i
        |=> ctrl_q == `OT_CTRL_RESET && month_q == `OT_MONTH_RESET
            && year_q == `OT_YEAR_RESET && rdata_o == 8'h00)
        else $error("reset state wrong");

    // =============================================================
    // cover points
    c_first: cover property (@(posedge clk_i) take && !held);
    c_over: cover property (@(posedge clk_i) take && held);
    c_clear: cover property (@(posedge clk_i) clr && held);
    c_race: cover property (@(posedge clk_i) take && clr);
    c_frozen: cover property (@(posedge clk_i) !ce_i && ot_event_i);
endmodule : ot_stamp_month_year

// ==== testbench.sv ====
`timescale 1ns/1ns
`include "ot_stamp_regs.svh"
// =============================================================
// stamp register bench
module testbench;
    logic       clk_i       = 1'b0;
    logic       rst_n_i     = 1'b0;
    logic       ce_i        = 1'b1;
    logic [7:0] addr_i      = 8'h00;
    logic [7:0] wdata_i     = 8'h00;
    logic       wr_i        = 1'b0;
    logic       rd_i        = 1'b0;
    logic       ot_event_i  = 1'b0;
    logic [4:0] cal_month_i = 5'h00;
    logic [7:0] cal_year_i  = 8'h00;
    logic [7:0] rdata_o;
    int         failures    = 0;
    int         comparisons = 0;

    ot_stamp_month_year i_ot_stamp_month_year (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .ot_event_i(ot_event_i),
        .cal_month_i(cal_month_i), .cal_year_i(cal_year_i)
    );

    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // =============================================================
    // bus and event tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        comparisons++;
        if (rdata_o !== exp) begin
            failures++;
            $display("Error rdata %h expected %h seen %h", a, exp, rdata_o);
        end
    endtask : rd

    task automatic ev(input logic [4:0] m, input logic [7:0] y);
        @(posedge clk_i);
        ot_event_i  <= 1'b1;
        cal_month_i <= m;
        cal_year_i  <= y;
        @(posedge clk_i);
        ot_event_i  <= 1'b0;
    endtask : ev

    task automatic wrap_up;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    // =============================================================
    // tests
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(`OT_ADDR_MONTH, 8'h00);
        rd(`OT_ADDR_YEAR, 8'h00);
        rd(8'h40, 8'h00);
        ev(5'h07, 8'h21);
        rd(`OT_ADDR_YEAR, 8'h00);
        rd(`OT_ADDR_STAT, 8'h00);
        wr(`OT_ADDR_CTRL, 8'h01);
        ev(5'h12, 8'h99);
        ev(5'h05, 8'h23);
        rd(`OT_ADDR_MONTH, 8'h12);
        rd(`OT_ADDR_YEAR, 8'h99);
        rd(`OT_ADDR_STAT, 8'h01);
        wr(`OT_ADDR_CTRL, 8'h05);
        rd(`OT_ADDR_YEAR, 8'h00);
        rd(`OT_ADDR_MONTH, 8'h00);
        rd(`OT_ADDR_CTRL, 8'h01);
        wr(`OT_ADDR_CTRL, 8'h03);
        ev(5'h09, 8'h45);
        ev(5'h11, 8'h50);
        rd(`OT_ADDR_MONTH, 8'h11);
        wr(`OT_ADDR_YEAR, 8'h77);
        rd(`OT_ADDR_YEAR, 8'h50);
        @(posedge clk_i);
        #1;
        comparisons++;
        if (rdata_o !== 8'h00) begin
            failures++;
            $display("Error rdata idle expected 00 seen %h", rdata_o);
        end
        // clock enable low freezes capture and writes
        @(posedge clk_i);
        ce_i <= 1'b0;
        ev(5'h01, 8'h02);
        wr(`OT_ADDR_CTRL, 8'h00);
        @(posedge clk_i);
        ce_i <= 1'b1;
        rd(`OT_ADDR_YEAR, 8'h50);
        rd(`OT_ADDR_CTRL, 8'h03);
        // capture and clear on one edge: capture wins
        fork
            ev(5'h03, 8'h04);
            wr(`OT_ADDR_CTRL, 8'h07);
        join
        rd(`OT_ADDR_YEAR, 8'h04);
        rd(`OT_ADDR_MONTH, 8'h03);
        rd(`OT_ADDR_STAT, 8'h01);
        // second reset in mid-run
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(`OT_ADDR_YEAR, 8'h00);
        rd(`OT_ADDR_CTRL, 8'h00);
        rd(`OT_ADDR_STAT, 8'h00);
        wrap_up();
    end

    initial begin
        #100000;
        failures++;
        wrap_up();
    end
endmodule : testbench
